// [src/port_cde_pkg.sv]
package port_cde_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_C_DATA = 8'h02;
  localparam logic [7:0] IDX_D_DATA = 8'h03;
  localparam logic [7:0] IDX_C_DIR = 8'h06;
  localparam logic [7:0] IDX_D_DIR = 8'h07;
  localparam logic [7:0] IDX_E_DATA = 8'h08;
  localparam logic [7:0] IDX_E_DIR = 8'h0c;
  localparam logic [7:0] IDX_PERIPH_A = 8'h10;
  localparam logic [7:0] IDX_PERIPH_B = 8'h11;

  // ----------------------------------------------------------------
  // Port widths and special pins
  // ----------------------------------------------------------------
  localparam int C_W = 5;
  localparam int D_W = 7;
  localparam int E_W = 8;
  localparam int PIN_W = C_W + D_W + E_W;
  localparam int CLK_OUT_EN_BIT = 7;
  localparam int MCLK_PIN = 2;
  localparam int TCLK_PIN = 6;
  localparam int SS_PIN = 4;
  localparam int RX_PIN = 1;

  // ----------------------------------------------------------------
  // Peripheral select fields
  // ----------------------------------------------------------------
  localparam int ADC_SEL_LSB = 0;
  localparam int PS_LSB = 5;
  localparam int SPI_ON_BIT = 0;
  localparam int MASTER_BIT = 1;
  localparam int FAULT_BIT = 2;
  localparam int SCI_BIT = 3;
  localparam int ELS0_LSB = 4;
  localparam int ELS1_LSB = 6;
  localparam logic [4:0] ADC_D_BASE = 5'h08;
  localparam logic [2:0] PS_EXT = 3'h7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [4:0] ADC_SEL_RST = 5'h1f;
  localparam logic [2:0] PS_RST = 3'h0;

  function automatic logic [7:0] addr_of(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

endpackage

// [src/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; level changes once stages two and three agree
module pin_sync #(
  parameter int W = 20
) (
  input wire logic clk,          // System clock
  input wire logic rst_n,        // Async reset, active low
  input wire logic [W-1:0] din,  // Raw pin levels
  output logic [W-1:0] level     // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  always_comb
  begin
    sync_next = sync_reg;
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
    sync_next.s3 = sync_reg.s2;
    sync_next.lvl = (~(sync_reg.s2 ^ sync_reg.s3) & sync_reg.s3) |
                    ((sync_reg.s2 ^ sync_reg.s3) & sync_reg.lvl);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_reg <= '0;
    end
    else
    begin
      sync_reg <= sync_next;
    end
  end

  assign level = sync_reg.lvl;

endmodule

`default_nettype wire

// [src/port_cde_pin_logic.sv]
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Function
// (RL1) Clock-output enable drives system clock on C2
// (RL2) Clock output overrides C2 direction bit
// (RL3) Reset clears clock-output enable
// (RL4) Direction one drives pin, zero floats
// (RL5) Reset clears port C direction bits
// (RL6) Reset clears port D direction bits
// (RL7) Port C read: latch if output, else pin; C2 reads zero while clock output is on
// (RL8) Port D read: latch if output, else pin
// (RL9) Data writes always update the latch; the code skips the update when byteenable[0] is low
// (RL10) ADC-selected input bit of D reads zero
// (RL11) Timer ignores D direction; read still uses it
// (RL12) Prescale external select takes D6 as clock
// (RL13) SPI off frees four E pins
// (RL14) Master without fault detect frees select pin
// (RL15) SPI slave: select pin always input
// (RL16) SPI ignores E direction; read still uses it
// (RL17) Edge/level bits give E3, E2 to timer
// (RL18) SCI owns E1 input and E0 output
// (RL19) Software writes data before setting direction
// (RL20) Owning peripheral beats latch and direction
module port_cde_pin_logic (
  input wire logic clk,               // 50 MHz system clock
  input wire logic rst_n,             // Async reset, active low
  input wire logic [7:0] address,     // Avalon byte address
  input wire logic read,              // Avalon read
  input wire logic write,             // Avalon write
  input wire logic [31:0] writedata,  // Avalon write data
  input wire logic [3:0] byteenable,  // Avalon byte enables
  output logic [31:0] readdata,       // Avalon read data
  output logic waitrequest,           // Avalon wait request
  input wire logic mclk_src,          // Internal system clock level
  input wire logic [4:0] pc_in,       // Port C pin levels
  output logic [4:0] pc_out,          // Port C pin drive values
  output logic [4:0] pc_oe,           // Port C output enables
  input wire logic [6:0] pd_in,       // Port D pin levels
  output logic [6:0] pd_out,          // Port D pin drive values
  output logic [6:0] pd_oe,           // Port D output enables
  input wire logic [7:0] pe_in,       // Port E pin levels
  output logic [7:0] pe_out,          // Port E pin drive values
  output logic [7:0] pe_oe,           // Port E output enables
  input wire logic [7:0] periph_e_out, // SPI/timer/SCI drive values
  input wire logic [7:0] periph_e_oe, // SPI/timer/SCI output enables
  output logic [7:0] periph_e_in,     // Synchronised E pins to peripherals
  output logic timer_ext_clk_in       // External timer clock from D6
);
  import port_cde_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [C_W-1:0] c_lat;
    logic [C_W-1:0] c_dir;
    logic clk_out_en;
    logic [D_W-1:0] d_lat;
    logic [D_W-1:0] d_dir;
    logic [E_W-1:0] e_lat;
    logic [E_W-1:0] e_dir;
    logic [4:0] adc_channel_select;
    logic [2:0] prescale_select;
    logic spi_on;
    logic spi_master_sel;
    logic fault_detect_en;
    logic async_serial_on;
    logic [1:0] els0;
    logic [1:0] els1;
    logic wait_r;
    logic [7:0] rdata;
    logic [C_W-1:0] pc_out;
    logic [C_W-1:0] pc_oe;
    logic [D_W-1:0] pd_out;
    logic [D_W-1:0] pd_oe;
    logic [E_W-1:0] pe_out;
    logic [E_W-1:0] pe_oe;
    logic tclk;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [PIN_W-1:0] pin_level;
  logic [C_W-1:0] c_pin;
  logic [D_W-1:0] d_pin;
  logic [E_W-1:0] e_pin;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_mux(input logic [7:0] dir,
                                          input logic [7:0] lat,
                                          input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction

  function automatic logic [D_W-1:0] adc_mask(input logic [4:0] sel);
    logic [D_W-1:0] m;
    m = '0;
    for (int i = 0; i < D_W; i++)
    begin
      m[i] = (sel == ADC_D_BASE + 5'(i));
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  pin_sync #(
    .W(PIN_W)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({pe_in, pd_in, pc_in}),
    .level(pin_level)
  );

  assign c_pin = pin_level[C_W-1:0];
  assign d_pin = pin_level[C_W+D_W-1:C_W];
  assign e_pin = pin_level[PIN_W-1:C_W+D_W];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [D_W-1:0] d_own;
  logic [E_W-1:0] e_own;
  logic [E_W-1:0] e_poe;
  logic [7:0] rv;
  logic tclk_sel;
  logic ss_gpio;

  always_comb
  begin
    st_next = st_reg;
    rv = 8'h00;
    tclk_sel = (st_reg.prescale_select == PS_EXT);
    ss_gpio = !st_reg.spi_on ||
              (st_reg.spi_master_sel && !st_reg.fault_detect_en); // [RL14]
    // Port E ownership by peripherals
    e_own = '0;
    e_own[7:5] = {3{st_reg.spi_on}}; // [RL13]
    e_own[SS_PIN] = !ss_gpio;
    e_own[3] = (st_reg.els1 != 2'b00); // [RL17]
    e_own[2] = (st_reg.els0 != 2'b00); // [RL17]
    e_own[RX_PIN] = st_reg.async_serial_on; // [RL18]
    e_own[0] = st_reg.async_serial_on; // [RL18]
    e_poe = periph_e_oe;
    e_poe[SS_PIN] = 1'b0; // [RL15]
    e_poe[RX_PIN] = 1'b0; // [RL18]
    st_next.pe_oe = (e_own & e_poe) | (~e_own & st_reg.e_dir); // [RL20] [RL16]
    st_next.pe_out = (e_own & periph_e_out) | (~e_own & st_reg.e_lat);
    // Port D: ADC channels and timer clock float the pin
    d_own = adc_mask(st_reg.adc_channel_select);
    d_own[TCLK_PIN] = d_own[TCLK_PIN] | tclk_sel; // [RL12] [RL11]
    st_next.pd_oe = ~d_own & st_reg.d_dir; // [RL4]
    st_next.pd_out = st_reg.d_lat;
    st_next.tclk = tclk_sel & d_pin[TCLK_PIN]; // [RL12]
    st_next.pc_oe = st_reg.c_dir; // [RL4]
    st_next.pc_out = st_reg.c_lat;
    if (st_reg.clk_out_en)
    begin
      st_next.pc_oe[MCLK_PIN] = 1'b1; // [RL1] [RL2]
      st_next.pc_out[MCLK_PIN] = mclk_src; // [RL1]
    end
    case (address)
      addr_of(IDX_C_DATA):
      begin
        rv[C_W-1:0] = 5'(read_mux(8'(st_reg.c_dir), 8'(st_reg.c_lat),
                                  8'(c_pin))); // [RL7]
        rv[MCLK_PIN] = rv[MCLK_PIN] & !st_reg.clk_out_en; // [RL1]
      end
      addr_of(IDX_D_DATA):
      begin
        rv[D_W-1:0] = 7'(read_mux(8'(st_reg.d_dir), 8'(st_reg.d_lat),
                                  8'(d_pin))) & // [RL8] [RL10]
                      ~(adc_mask(st_reg.adc_channel_select) & ~st_reg.d_dir);
      end
      addr_of(IDX_E_DATA):
      begin
        rv = read_mux(st_reg.e_dir, st_reg.e_lat, e_pin); // [RL16]
      end
      addr_of(IDX_C_DIR):
      begin
        rv[C_W-1:0] = st_reg.c_dir;
        rv[CLK_OUT_EN_BIT] = st_reg.clk_out_en;
      end
      addr_of(IDX_D_DIR):
      begin
        rv[D_W-1:0] = st_reg.d_dir;
      end
      addr_of(IDX_E_DIR):
      begin
        rv = st_reg.e_dir;
      end
      addr_of(IDX_PERIPH_A):
      begin
        rv = {st_reg.prescale_select, st_reg.adc_channel_select};
      end
      addr_of(IDX_PERIPH_B):
      begin
        rv = {st_reg.els1, st_reg.els0, st_reg.async_serial_on,
              st_reg.fault_detect_en, st_reg.spi_master_sel, st_reg.spi_on};
      end
      default:
      begin
        rv = 8'h00;
      end
    endcase
    // Bus handshake: one wait cycle, then a single accept cycle
    st_next.wait_r = 1'b1;
    if ((read || write) && st_reg.wait_r)
    begin
      st_next.wait_r = 1'b0;
      st_next.rdata = rv;
    end
    if (write && !st_reg.wait_r && byteenable[0])
    begin
      case (address)
        addr_of(IDX_C_DATA):
        begin
          st_next.c_lat = writedata[C_W-1:0]; // [RL9]
        end
        addr_of(IDX_D_DATA):
        begin
          st_next.d_lat = writedata[D_W-1:0]; // [RL9]
        end
        addr_of(IDX_E_DATA):
        begin
          st_next.e_lat = writedata[E_W-1:0]; // [RL9]
        end
        addr_of(IDX_C_DIR):
        begin
          st_next.c_dir = writedata[C_W-1:0];
          st_next.clk_out_en = writedata[CLK_OUT_EN_BIT];
        end
        addr_of(IDX_D_DIR):
        begin
          st_next.d_dir = writedata[D_W-1:0];
        end
        addr_of(IDX_E_DIR):
        begin
          st_next.e_dir = writedata[E_W-1:0];
        end
        addr_of(IDX_PERIPH_A):
        begin
          st_next.adc_channel_select = writedata[PS_LSB-1:ADC_SEL_LSB];
          st_next.prescale_select = writedata[PS_LSB+2:PS_LSB];
        end
        addr_of(IDX_PERIPH_B):
        begin
          st_next.spi_on = writedata[SPI_ON_BIT];
          st_next.spi_master_sel = writedata[MASTER_BIT];
          st_next.fault_detect_en = writedata[FAULT_BIT];
          st_next.async_serial_on = writedata[SCI_BIT];
          st_next.els0 = writedata[ELS0_LSB+1:ELS0_LSB];
          st_next.els1 = writedata[ELS1_LSB+1:ELS1_LSB];
        end
        default:
        begin
          st_next.wait_r = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.c_dir <= DIR_RST[C_W-1:0]; // [RL5]
      st_reg.clk_out_en <= 1'b0; // [RL3]
      st_reg.d_dir <= DIR_RST[D_W-1:0]; // [RL6]
      st_reg.e_dir <= DIR_RST;
      st_reg.c_lat <= LAT_RST[C_W-1:0];
      st_reg.d_lat <= LAT_RST[D_W-1:0];
      st_reg.e_lat <= LAT_RST;
      st_reg.adc_channel_select <= ADC_SEL_RST;
      st_reg.prescale_select <= PS_RST;
      st_reg.wait_r <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign readdata = {24'h000000, st_reg.rdata};
  assign waitrequest = st_reg.wait_r;
  assign pc_out = st_reg.pc_out;
  assign pc_oe = st_reg.pc_oe;
  assign pd_out = st_reg.pd_out;
  assign pd_oe = st_reg.pd_oe;
  assign pe_out = st_reg.pe_out;
  assign pe_oe = st_reg.pe_oe;
  assign periph_e_in = e_pin;
  assign timer_ext_clk_in = st_reg.tclk;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_CLK_OUT: assert property ( // [RL1] [RL2]
    st_reg.clk_out_en |=> pc_oe[MCLK_PIN] && pc_out[MCLK_PIN] == $past(mclk_src))
    else $error("clock output not driven on C2");
  AST_C2_GPIO: assert property ( // [RL1] [RL4]
    !st_reg.clk_out_en |=> pc_oe[MCLK_PIN] == $past(st_reg.c_dir[MCLK_PIN]))
    else $error("C2 enable does not follow direction");
  AST_RESET: assert property ( // [RL3] [RL5] [RL6]
    @(posedge clk) disable iff (1'b0)
    !rst_n |-> !st_reg.clk_out_en && st_reg.c_dir == '0 &&
               st_reg.d_dir == '0 && pc_oe == '0 && pd_oe == '0)
    else $error("reset left a direction or clock enable set");
  AST_RD_C: assert property ( // [RL7]
    (read && address == addr_of(IDX_C_DATA) && waitrequest &&
     !st_reg.clk_out_en) |=> !waitrequest && readdata[0] ==
    ($past(st_reg.c_dir[0]) ? $past(st_reg.c_lat[0]) : $past(c_pin[0])))
    else $error("port C read value wrong");
  AST_RD_D_ADC: assert property ( // [RL10] [RL8]
    (read && address == addr_of(IDX_D_DATA) && waitrequest &&
     st_reg.adc_channel_select == ADC_D_BASE) |=>
    readdata[0] == ($past(st_reg.d_dir[0]) && $past(st_reg.d_lat[0])))
    else $error("ADC-selected port D bit read wrong");
  AST_WR_LAT: assert property ( // [RL9]
    (write && !waitrequest && byteenable[0] &&
     address == addr_of(IDX_E_DATA)) |=> st_reg.e_lat == $past(writedata[7:0]))
    else $error("port E latch not written");
  AST_TCLK: assert property ( // [RL12] [RL11]
    (st_reg.prescale_select == PS_EXT) |=> !pd_oe[TCLK_PIN] &&
    timer_ext_clk_in == $past(d_pin[TCLK_PIN]))
    else $error("timer clock pin not taken");
  AST_SPI_OWN: assert property ( // [RL13] [RL16] [RL20]
    st_reg.spi_on |=> pe_oe[7] == $past(periph_e_oe[7]) &&
                      pe_out[7] == $past(periph_e_out[7]))
    else $error("SPI clock pin not owned by SPI");
  AST_SS_SLAVE: assert property ( // [RL15]
    (st_reg.spi_on && !st_reg.spi_master_sel) |=> !pe_oe[SS_PIN])
    else $error("slave select driven in slave mode");
  AST_SS_GPIO: assert property ( // [RL14]
    (st_reg.spi_on && st_reg.spi_master_sel && !st_reg.fault_detect_en)
    |=> pe_oe[SS_PIN] == $past(st_reg.e_dir[SS_PIN]))
    else $error("slave select not general purpose");
  AST_TIM_CH: assert property ( // [RL17]
    (st_reg.els0 != 2'b00) |=> pe_oe[2] == $past(periph_e_oe[2]))
    else $error("timer channel pin not owned");
  AST_SCI_RX: assert property ( // [RL18]
    st_reg.async_serial_on |=> !pe_oe[RX_PIN] &&
    pe_out[0] == $past(periph_e_out[0]))
    else $error("SCI pins not owned");
  AST_HANDSHAKE: assert property (
    ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest)
    else $error("bus accept not a single cycle");
  COV_RD_C: cover property (read && !waitrequest &&
                            address == addr_of(IDX_C_DATA));
  COV_CLK_OUT: cover property (st_reg.clk_out_en && pc_oe[MCLK_PIN]);
  COV_SPI_SLAVE: cover property (st_reg.spi_on && !st_reg.spi_master_sel);
  COV_ADC_READ: cover property (read && !waitrequest &&
                                address == addr_of(IDX_D_DATA) &&
                                st_reg.adc_channel_select == ADC_D_BASE);

endmodule

`default_nettype wire

// [verif/pin_world.sv]
`timescale 1ns/1ps
`default_nettype none

// --------------------
// Outside world at the port pins
// --------------------
module pin_world (
  input wire logic clk,             // System clock
  input wire logic [19:0] drv_val,  // Level driven from outside
  input wire logic [19:0] drv_en,   // Outside driver active
  input wire logic [19:0] dut_out,  // Device drive values
  input wire logic [19:0] dut_oe,   // Device output enables
  output logic [19:0] level         // Resolved pin levels
);
  logic [19:0] float_reg = 20'h5a5a5;

  // Undriven pins wander so a stale level never reads as valid
  always_ff @(posedge clk)
  begin
    float_reg <= ~float_reg;
  end

  assign level = (dut_oe & dut_out) | (~dut_oe & drv_en & drv_val)
    | (~dut_oe & ~drv_en & float_reg);
endmodule

`default_nettype wire

// [verif/port_cde_pin_logic_test.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module port_cde_pin_logic_test;
  import port_cde_pkg::*;

  logic clk, rst_n, read, write, waitrequest, mclk_src, timer_ext_clk_in;
  logic [7:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [4:0] pc_out, pc_oe;
  logic [6:0] pd_out, pd_oe;
  logic [7:0] pe_out, pe_oe, periph_e_out, periph_e_oe, periph_e_in;
  logic [19:0] drv_val, drv_en, level;
  int err_total, cmp_count, m_ce, m_pa, m_pb;
  int m_lat[3];
  int m_dir[3];

  port_cde_pin_logic i_dut (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .mclk_src(mclk_src), .pc_in(level[4:0]),
    .pc_out(pc_out), .pc_oe(pc_oe), .pd_in(level[11:5]), .pd_out(pd_out),
    .pd_oe(pd_oe), .pe_in(level[19:12]), .pe_out(pe_out), .pe_oe(pe_oe),
    .periph_e_out(periph_e_out), .periph_e_oe(periph_e_oe),
    .periph_e_in(periph_e_in), .timer_ext_clk_in(timer_ext_clk_in));

  pin_world i_world (.clk(clk), .drv_val(drv_val), .drv_en(drv_en),
    .dut_out({pe_out, pd_out, pc_out}), .dut_oe({pe_oe, pd_oe, pc_oe}),
    .level(level));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // --------------------
  // Bus access and model
  // --------------------
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr,
    input logic [7:0] wd, input logic [3:0] be, output logic [31:0] rd);
    int n;
    address <= {idx[5:0], 2'b00};
    writedata <= {24'h0, wd};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    rd = readdata;
    if (waitrequest !== 1'b0)
    begin
      err_total++;
      stop_test();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(idx, 1'b1, d, 4'h1, rd);
    case (idx)
      IDX_C_DATA: m_lat[0] = int'(d[4:0]);
      IDX_D_DATA: m_lat[1] = int'(d[6:0]);
      IDX_E_DATA: m_lat[2] = int'(d);
      IDX_C_DIR:
      begin
        m_dir[0] = int'(d[4:0]);
        m_ce = int'(d[7]);
      end
      IDX_D_DIR: m_dir[1] = int'(d[6:0]);
      IDX_E_DIR: m_dir[2] = int'(d);
      IDX_PERIPH_A: m_pa = int'(d);
      IDX_PERIPH_B: m_pb = int'(d);
      default: ;
    endcase
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] rd;
    bus(idx, 1'b0, 8'h00, 4'h0, rd);
    `CHK(rd, {24'h0, e})
  endtask

  task automatic check_all();
    logic [19:0] eoe, eout, lvl;
    logic [7:0] ec, ed;
    int adc;
    repeat (8) @(posedge clk);
    eoe = {m_dir[2][7:0], m_dir[1][6:0], m_dir[0][4:0]};
    eout = {m_lat[2][7:0], m_lat[1][6:0], m_lat[0][4:0]};
    adc = m_pa % 32;
    if (m_ce != 0)
    begin
      eoe[2] = 1'b1;
      eout[2] = mclk_src;
    end
    if (adc >= 8 && adc <= 14)
      eoe[adc - 3] = 1'b0;
    if (m_pa / 32 == 7)
      eoe[11] = 1'b0;
    if (m_pb[0])
    begin
      eoe[19:17] = periph_e_oe[7:5];
      eout[19:17] = periph_e_out[7:5];
      if (!(m_pb[1] && !m_pb[2]))
        eoe[16] = 1'b0;
    end
    if (m_pb[5:4] != 2'b00)
    begin
      eoe[14] = periph_e_oe[2];
      eout[14] = periph_e_out[2];
    end
    if (m_pb[7:6] != 2'b00)
    begin
      eoe[15] = periph_e_oe[3];
      eout[15] = periph_e_out[3];
    end
    if (m_pb[3])
    begin
      eoe[13] = 1'b0;
      eoe[12] = periph_e_oe[0];
      eout[12] = periph_e_out[0];
    end
    lvl = (eoe & eout) | (~eoe & drv_val);
    `CHK({pe_oe, pd_oe, pc_oe}, eoe)
    `CHK({pe_out, pd_out, pc_out} & eoe, eout & eoe)
    `CHK(periph_e_in, lvl[19:12])
    `CHK(timer_ext_clk_in, (m_pa / 32 == 7) ? lvl[11] : 1'b0)
    ec = {3'h0, (m_dir[0][4:0] & m_lat[0][4:0]) | (~m_dir[0][4:0] & lvl[4:0])};
    if (m_ce != 0)
      ec[2] = 1'b0;
    ed = {1'b0, (m_dir[1][6:0] & m_lat[1][6:0]) | (~m_dir[1][6:0] & lvl[11:5])};
    if (adc >= 8 && adc <= 14)
      ed[adc - 8] = m_dir[1][adc - 8] & m_lat[1][adc - 8];
    rdchk(IDX_C_DATA, ec);
    rdchk(IDX_D_DATA, ed);
    rdchk(IDX_E_DATA, (m_dir[2][7:0] & m_lat[2][7:0])
      | (~m_dir[2][7:0] & lvl[19:12]));
    rdchk(IDX_C_DIR, {m_ce[0], 2'b00, m_dir[0][4:0]});
    rdchk(IDX_D_DIR, {1'b0, m_dir[1][6:0]});
  endtask

  task automatic do_reset(input int cycles);
    rst_n <= 1'b0;
    repeat (cycles) @(posedge clk);
    `CHK({pe_oe, pd_oe, pc_oe, waitrequest, timer_ext_clk_in}, 22'h2)
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    m_lat = '{0, 0, 0};
    m_dir = '{0, 0, 0};
    m_ce = 0;
    m_pa = 31;
    m_pb = 0;
    check_all();
  endtask

  // --------------------
  // Main sequence
  // --------------------
  initial
  begin
    logic [31:0] rd;
    err_total = 0;
    cmp_count = 0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'h0;
    mclk_src = 1'b0;
    periph_e_out = 8'h00;
    periph_e_oe = 8'h00;
    drv_val = 20'h0;
    drv_en = 20'hfffff;
    void'($urandom(32'hed791135));
    do_reset(16);
    for (int i = 0; i < 300; i++)
    begin
      drv_val <= 20'($urandom);
      mclk_src <= 1'($urandom);
      periph_e_out <= 8'($urandom);
      periph_e_oe <= 8'($urandom);
      wr(IDX_PERIPH_A, 8'($urandom));
      wr(IDX_PERIPH_B, 8'(i));
      // Latches first, then directions, so outputs never glitch
      wr(IDX_C_DATA, 8'($urandom));
      wr(IDX_D_DATA, 8'($urandom));
      wr(IDX_E_DATA, 8'($urandom));
      wr(IDX_C_DIR, 8'($urandom));
      wr(IDX_D_DIR, 8'($urandom));
      wr(IDX_E_DIR, 8'($urandom));
      check_all();
    end
    bus(IDX_E_DATA, 1'b1, 8'($urandom), 4'h0, rd);
    check_all();
    bus(8'h3f, 1'b1, 8'hff, 4'h1, rd);
    rdchk(8'h3f, 8'h00);
    check_all();
    do_reset(3);
    stop_test();
  end
endmodule

`default_nettype wire
